//--- common/sdp_pkg.sv
// Purpose: Shared constants and carrier types for the SDRAM pin front end
// Assumes: 12-bit row, 8-bit column, four banks, 16-bit data
// Notes: Command codes are the {ras_n, cas_n, we_n} levels with chip select low
package sdp_pkg;
   // Array geometry
   localparam int ROW_W = 12;
   localparam int COL_W = 8;
   localparam int BANK_W = 2;
   localparam int BANKS = 4;
   localparam int DATA_W = 16;
   localparam int BYTES = 2;
   // Address bit that widens a precharge to every bank
   localparam int PRE_ALL_BIT = 10;
   // Cycles from a sampled byte mask to its effect on a read output
   localparam int MASK_READ_LATENCY = 2;
   // Refresh commands needed during initialisation
   localparam logic [3:0] INIT_REFRESHES = 4'h8;
   // Write buffer depth
   localparam int WR_FIFO_DEPTH = 16;
   // Reset values
   localparam logic [ROW_W-1:0] MODE_RESET = 12'h000;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   // Command codes on {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_MODE_SET = 3'h0;
   localparam logic [2:0] CMD_REFRESH = 3'h1;
   localparam logic [2:0] CMD_PRECHARGE = 3'h2;
   localparam logic [2:0] CMD_ACTIVATE = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_BURST_STOP = 3'h6;
   localparam logic [2:0] CMD_NO_OP = 3'h7;

   // Command strobes as seen on the pins
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdp_cmd_pins_type;

   // One accepted write towards the storage core
   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
      logic [DATA_W-1:0] data;
      logic [BYTES-1:0] byte_en;
   } sdp_wr_entry_type;

   // One accepted read towards the storage core
   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0] row;
      logic [COL_W-1:0] col;
   } sdp_rd_req_type;

   // Clocking state of the device
   typedef enum logic [3:0] {
      PWR_RUN = 4'h1,
      PWR_DOWN = 4'h2,
      PWR_SUSPEND = 4'h4,
      PWR_SELF_REFRESH = 4'h8
   } sdp_pwr_type;
endpackage

//--- hdl/sdp_fifo.sv
// Purpose: Write buffer between the pin side and the storage core
// Assumes: Single clock, registered output stage
// Notes: Holds DEPTH words in the array plus one in the output register
`timescale 1ns/100ps
module sdp_fifo #(
   parameter int WIDTH = 41,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic [AW-1:0] wptr, next_wptr; // Write pointer
   logic [AW-1:0] rptr, next_rptr; // Read pointer
   logic [AW:0] count, next_count; // Words in the array
   logic next_out_valid; // Output stage occupancy
   logic push, pop; // Array strobes

   // Ready while the array has room
   assign in_ready = (count < (AW+1)'(DEPTH));

   // Pointer and occupancy update
   always_comb
   begin
      push = in_valid && in_ready;
      pop = (count != '0) && (!out_valid || out_ready);
      next_wptr = push ? wptr + 1'b1 : wptr;
      next_rptr = pop ? rptr + 1'b1 : rptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      // Output stage keeps its word until taken
      if (pop)
         next_out_valid = 1'b1;
      else if (out_ready)
         next_out_valid = 1'b0;
      else
         next_out_valid = out_valid;
   end

   // Control registers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
      end
      else
      begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         out_valid <= next_out_valid;
      end
   end

   // Array and registered read port
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         out_data <= '0;
      else if (pop)
         out_data <= mem[rptr];
   end

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wptr] <= in_data;
   end
endmodule

//--- hdl/sdp_front.sv
// Purpose: Pin-level command front end of a four-bank 16-bit SDRAM
// Assumes: All pins synchronous to ref_clk; storage core sits on the user side
// Notes: One word per read or write; burst sequencing lives elsewhere
`timescale 1ns/100ps
module sdp_front #(
   parameter int FIFO_DEPTH = sdp_pkg::WR_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // Command pins
   input wire logic cke,
   input wire sdp_pkg::sdp_cmd_pins_type cmd,
   input wire logic [sdp_pkg::ROW_W-1:0] addr,
   input wire logic bank_select_high,
   input wire logic bank_select_low,
   input wire logic upper_byte_mask,
   input wire logic lower_byte_mask,
   // Data pins
   input wire logic [sdp_pkg::DATA_W-1:0] dq_in,
   output logic [sdp_pkg::DATA_W-1:0] dq_out,
   output logic [sdp_pkg::BYTES-1:0] dq_oe,
   // Core read side
   output logic rd_req_valid,
   output sdp_pkg::sdp_rd_req_type rd_req,
   input wire logic [sdp_pkg::DATA_W-1:0] rd_data,
   // Core write side
   output logic wr_valid,
   output sdp_pkg::sdp_wr_entry_type wr_entry,
   input wire logic wr_ready,
   // Status
   output logic init_done,
   output logic [sdp_pkg::ROW_W-1:0] mode_value,
   output logic low_power,
   output logic wr_overflow
);
   localparam int NB = sdp_pkg::BANKS;

   // Decode
   logic [2:0] code; // Strobe levels
   logic sel; // Command decoder enabled
   logic [sdp_pkg::BANK_W-1:0] bank_idx; // Addressed bank
   logic [sdp_pkg::BYTES-1:0] mask; // Sampled byte masks
   logic is_mrs, is_ref, is_pre, is_act, is_wr, is_rd;
   logic any_open; // Some bank holds a row
   logic issue_mrs, issue_rd, issue_wr, push, fifo_ready;
   sdp_pkg::sdp_wr_entry_type push_entry; // Word offered to the buffer

   // Bank state
   logic bank_open [NB];
   logic next_open [NB];
   logic [sdp_pkg::ROW_W-1:0] bank_row [NB];
   logic [sdp_pkg::ROW_W-1:0] next_row [NB];

   // Mode, init and power state
   sdp_pkg::sdp_pwr_type pwr, next_pwr;
   logic mode_valid, next_mode_valid; // Mode register programmed
   logic [sdp_pkg::ROW_W-1:0] next_mode_value;
   logic pre_all_seen, next_pre_all_seen; // First precharge-all seen
   logic [3:0] ref_cnt, next_ref_cnt; // Init refreshes, saturating
   logic next_overflow;

   // Read pipeline
   logic rp1, rp2, next_rp1, next_rp2; // Read in flight per stage
   logic [sdp_pkg::BYTES-1:0] rm1, rm2; // Masks travelling with the read
   logic [sdp_pkg::DATA_W-1:0] rdat2, next_rdat2;
   logic [sdp_pkg::DATA_W-1:0] next_dq_out;
   logic [sdp_pkg::BYTES-1:0] next_dq_oe;
   logic next_rd_req_valid;
   sdp_pkg::sdp_rd_req_type next_rd_req;

   // Command decode from the sampled strobes
   always_comb
   begin
      code = {cmd.ras_n, cmd.cas_n, cmd.we_n};
      sel = !cmd.cs_n && (pwr == sdp_pkg::PWR_RUN) && cke;
      bank_idx = {bank_select_high, bank_select_low};
      mask = {upper_byte_mask, lower_byte_mask};
      is_mrs = sel && (code == sdp_pkg::CMD_MODE_SET);
      is_ref = sel && (code == sdp_pkg::CMD_REFRESH);
      is_pre = sel && (code == sdp_pkg::CMD_PRECHARGE);
      is_act = sel && (code == sdp_pkg::CMD_ACTIVATE);
      is_wr = sel && (code == sdp_pkg::CMD_WRITE);
      is_rd = sel && (code == sdp_pkg::CMD_READ);
      any_open = 1'b0;
      for (int b = 0; b < NB; b++)
         any_open = any_open | bank_open[b];
      // Mode set only with every bank closed
      issue_mrs = is_mrs && !any_open;
      // No access before the mode register is programmed
      issue_rd = is_rd && bank_open[bank_idx] && mode_valid;
      issue_wr = is_wr && bank_open[bank_idx] && mode_valid;
      // Fully masked writes are dropped in the command cycle itself; masked bytes clear byte_en
      push_entry.bank = bank_idx;
      push_entry.row = bank_row[bank_idx];
      push_entry.col = addr[sdp_pkg::COL_W-1:0];
      push_entry.data = dq_in;
      push_entry.byte_en = ~mask;
      push = issue_wr && (mask != '1) && fifo_ready;
   end

   // Per-bank open row tracking
   genvar g;
   generate
      for (g = 0; g < NB; g++)
      begin : gen_bank
         // Activate opens, precharge closes one or all
         assign next_open[g] = (is_act && bank_idx == g) ? 1'b1 :
            (is_pre && (addr[sdp_pkg::PRE_ALL_BIT] || bank_idx == g)) ? 1'b0 :
            bank_open[g];
         assign next_row[g] = (is_act && bank_idx == g && !bank_open[g]) ?
            addr : bank_row[g];
      end
   endgenerate

   // Bank registers
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int b = 0; b < NB; b++)
         begin
            bank_open[b] <= 1'b0;
            bank_row[b] <= '0;
         end
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            bank_open[b] <= next_open[b];
            bank_row[b] <= next_row[b];
         end
      end
   end

   // Power, mode and initialisation progress
   always_comb
   begin
      next_pwr = pwr;
      next_mode_valid = mode_valid || issue_mrs;
      next_mode_value = issue_mrs ? addr : mode_value;
      next_pre_all_seen = pre_all_seen || (is_pre && addr[sdp_pkg::PRE_ALL_BIT]);
      next_ref_cnt = ref_cnt;
      next_overflow = wr_overflow || (issue_wr && (mask != '1) && !fifo_ready);
      case (pwr)
         sdp_pkg::PWR_RUN:
         begin
            // Low clock enable picks the state by command and banks
            if (!cke)
            begin
               if (!cmd.cs_n && code == sdp_pkg::CMD_REFRESH && !any_open)
                  next_pwr = sdp_pkg::PWR_SELF_REFRESH;
               else if (any_open)
                  next_pwr = sdp_pkg::PWR_SUSPEND;
               else
                  next_pwr = sdp_pkg::PWR_DOWN;
            end
         end
         sdp_pkg::PWR_DOWN, sdp_pkg::PWR_SUSPEND, sdp_pkg::PWR_SELF_REFRESH:
         begin
            // Any sampled high clock enable resumes
            if (cke)
               next_pwr = sdp_pkg::PWR_RUN;
         end
         default:
            next_pwr = sdp_pkg::PWR_RUN;
      endcase
      // Self refresh entry counts as a refresh too
      if ((is_ref || next_pwr == sdp_pkg::PWR_SELF_REFRESH && pwr == sdp_pkg::PWR_RUN)
         && ref_cnt != sdp_pkg::INIT_REFRESHES)
         next_ref_cnt = ref_cnt + 4'h1;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pwr <= sdp_pkg::PWR_RUN;
         mode_valid <= 1'b0;
         mode_value <= sdp_pkg::MODE_RESET;
         pre_all_seen <= 1'b0;
         ref_cnt <= 4'h0;
         wr_overflow <= 1'b0;
         low_power <= 1'b0;
         init_done <= 1'b0;
      end
      else
      begin
         pwr <= next_pwr;
         mode_valid <= next_mode_valid;
         mode_value <= next_mode_value;
         pre_all_seen <= next_pre_all_seen;
         ref_cnt <= next_ref_cnt;
         wr_overflow <= next_overflow;
         low_power <= (next_pwr != sdp_pkg::PWR_RUN);
         init_done <= next_mode_valid && next_pre_all_seen
            && (next_ref_cnt == sdp_pkg::INIT_REFRESHES);
      end
   end

   // Read path: request, core data, then pins two edges after the command
   always_comb
   begin
      next_rd_req_valid = issue_rd;
      next_rd_req.bank = bank_idx;
      next_rd_req.row = bank_row[bank_idx];
      next_rd_req.col = addr[sdp_pkg::COL_W-1:0];
      next_rp1 = issue_rd;
      next_rp2 = rp1;
      next_rdat2 = rp1 ? rd_data : rdat2;
      next_dq_out = rp2 ? rdat2 : dq_out;
      next_dq_oe = rp2 ? ~rm2 : '0;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rd_req_valid <= 1'b0;
         rd_req <= '0;
         rp1 <= 1'b0;
         rp2 <= 1'b0;
         rm1 <= '0;
         rm2 <= '0;
         rdat2 <= sdp_pkg::DATA_RESET;
         dq_out <= sdp_pkg::DATA_RESET;
         dq_oe <= '0;
      end
      else
      begin
         rd_req_valid <= next_rd_req_valid;
         rd_req <= next_rd_req;
         rp1 <= next_rp1;
         rp2 <= next_rp2;
         rm1 <= mask;
         rm2 <= rm1;
         rdat2 <= next_rdat2;
         dq_out <= next_dq_out;
         dq_oe <= next_dq_oe;
      end
   end

   // Write buffer towards the core
   sdp_fifo #(
      .WIDTH($bits(sdp_pkg::sdp_wr_entry_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .in_valid(push),
      .in_ready(fifo_ready),
      .in_data(push_entry),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(wr_entry)
   );

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   a_read_request: assert property (issue_rd |=> rd_req_valid
      && rd_req.col == $past(addr[7:0]) && rd_req.bank == $past(bank_idx))
      else $error("read request does not follow read command");
   a_read_mask_float: assert property (issue_rd && upper_byte_mask |-> ##3 !dq_oe[1])
      else $error("masked read byte driven");
   a_read_drive_byte: assert property (issue_rd && !lower_byte_mask |-> ##3 dq_oe[0])
      else $error("unmasked read byte not driven");
   a_write_mask_drop: assert property (wr_valid |-> wr_entry.byte_en != 2'h0)
      else $error("fully masked write reached the core");
   a_deselect_ignored: assert property (cmd.cs_n |=> $stable(mode_value)
      && bank_open[0] == $past(bank_open[0]) && !rd_req_valid)
      else $error("deselected command acted on");
   a_precharge_all: assert property (is_pre && addr[10] |=> !any_open)
      else $error("precharge all left a bank open");
   a_mode_set_load: assert property (issue_mrs |=> mode_valid
      && mode_value == $past(addr))
      else $error("mode register not loaded");
   a_cke_low_power: assert property (pwr == sdp_pkg::PWR_RUN && !cke |=> low_power)
      else $error("low clock enable did not enter low power");
   a_no_early_access: assert property (!mode_valid |-> !issue_rd && !push)
      else $error("access before mode register programmed");
endmodule

//--- bench/sdp_ctrl_model.sv
// Purpose: Controller-side driver of the SDRAM command, mask and write data pins
// Assumes: Pins change 1 ns after the rising edge of ref_clk
// Notes: Power-up pause counted in cycles; data lines toggle when not written
`timescale 1ns/100ps
module sdp_ctrl_model #(
   parameter int PAUSE_CYCLES = 4000, // 200 us at 20 MHz
   parameter int MODE_GAP = 2 // Idle cycles after a mode set
) (
   // Clock
   input wire logic ref_clk,
   // Command pins
   output logic cke,
   output sdp_pkg::sdp_cmd_pins_type cmd,
   output logic [sdp_pkg::ROW_W-1:0] addr,
   output logic bank_select_high,
   output logic bank_select_low,
   output logic upper_byte_mask,
   output logic lower_byte_mask,
   // Write data
   output logic [sdp_pkg::DATA_W-1:0] dq_in
);
   // Power-up pin levels: no-op, masks and clock enable high
   initial
   begin
      cke = 1'b1;
      cmd = {1'b0, sdp_pkg::CMD_NO_OP};
      addr = 12'h000;
      {bank_select_high, bank_select_low} = 2'h0;
      {upper_byte_mask, lower_byte_mask} = 2'h3;
      dq_in = 16'h5a5a;
   end

   // One command cycle
   task automatic send(input logic cs_n, input logic [2:0] code,
      input logic [sdp_pkg::ROW_W-1:0] a, input logic [1:0] bank,
      input logic [1:0] m, input logic [sdp_pkg::DATA_W-1:0] d);
      @(posedge ref_clk);
      #1;
      cmd = {cs_n, code};
      addr = a;
      {bank_select_high, bank_select_low} = bank;
      {upper_byte_mask, lower_byte_mask} = m;
      // Unused data lines never hold the last value
      dq_in = (code == sdp_pkg::CMD_WRITE && !cs_n) ? d : ~dq_in;
   endtask

   // Idle cycle
   task automatic no_operation_state();
      send(1'b0, sdp_pkg::CMD_NO_OP, addr, 2'h0, 2'h0, 16'h0000);
   endtask

   // Clock enable change
   task automatic set_cke(input logic v);
      @(posedge ref_clk);
      #1;
      cke = v;
   endtask

   // Pause then close every bank before anything else
   task automatic power_up();
      repeat (PAUSE_CYCLES) @(posedge ref_clk);
      send(1'b0, sdp_pkg::CMD_PRECHARGE, 12'h400, 2'h0, 2'h3, 16'h0000);
   endtask

   // Program the mode register, then keep quiet for the set delay
   task automatic mode_set(input logic [sdp_pkg::ROW_W-1:0] v);
      send(1'b0, sdp_pkg::CMD_MODE_SET, v, 2'h0, 2'h0, 16'h0000);
      repeat (MODE_GAP) no_operation_state();
   endtask
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench of the SDRAM pin front end
// Assumes: Controller model drives the pins; bench plays the storage core
// Notes: Random values from a fixed seed with hand-picked corner cases
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("FAIL %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tb;
   logic ref_clk; // 20 MHz clock
   logic nrst; // Active low reset
   logic cke;
   sdp_pkg::sdp_cmd_pins_type cmd;
   logic [11:0] addr;
   logic bank_select_high, bank_select_low, upper_byte_mask, lower_byte_mask;
   logic [15:0] dq_in, dq_out, rd_data;
   logic [1:0] dq_oe;
   logic rd_req_valid, wr_valid, wr_ready, init_done, low_power, wr_overflow;
   sdp_pkg::sdp_rd_req_type rd_req;
   sdp_pkg::sdp_wr_entry_type wr_entry;
   logic [11:0] mode_value;
   int err_total = 0; // Mismatches
   int cmp_count = 0; // Comparisons
   logic [11:0] rows [4]; // Open row per bank
   logic seen; // Request seen by the core
   logic [11:0] mv;
   int n;

   // Clock generator
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Controller at the pins
   sdp_ctrl_model u_sdp_ctrl_model (.ref_clk(ref_clk), .cke(cke), .cmd(cmd), .addr(addr),
      .bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
      .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask), .dq_in(dq_in));

   // Device under test
   sdp_front u_sdp_front (.ref_clk(ref_clk), .nrst(nrst), .cke(cke), .cmd(cmd),
      .addr(addr), .bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
      .upper_byte_mask(upper_byte_mask), .lower_byte_mask(lower_byte_mask),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .rd_req_valid(rd_req_valid),
      .rd_req(rd_req), .rd_data(rd_data), .wr_valid(wr_valid), .wr_entry(wr_entry),
      .wr_ready(wr_ready), .init_done(init_done), .mode_value(mode_value),
      .low_power(low_power), .wr_overflow(wr_overflow));

   // Counts and verdict
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask

   // Open a row
   task automatic act(input logic [1:0] b, input logic [11:0] r);
      u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_ACTIVATE, r, b, 2'h0, 16'h0000);
      rows[b] = r;
   endtask

   // Read one word; seen tells whether the core was asked
   task automatic rd(input logic cs_n, input logic [1:0] b, input logic [7:0] c,
      input logic [1:0] m);
      logic [15:0] d;
      d = 16'($urandom());
      u_sdp_ctrl_model.send(cs_n, sdp_pkg::CMD_READ, {4'h0, c}, b, m, 16'h0000);
      u_sdp_ctrl_model.no_operation_state();
      seen = rd_req_valid;
      if (seen === 1'b1)
         `CHK("rd_req", {b, rows[b], c}, rd_req)
      rd_data = d;
      u_sdp_ctrl_model.no_operation_state();
      rd_data = ~d;
      u_sdp_ctrl_model.no_operation_state();
      if (seen === 1'b1)
         `CHK("dq_out", d, dq_out)
      `CHK("dq_oe", (seen === 1'b1) ? ~m : 2'h0, dq_oe)
   endtask

   // Write one word with the core ready; seen tells whether it arrived
   task automatic wr(input logic [1:0] b, input logic [7:0] c, input logic [1:0] m);
      logic [15:0] d;
      d = 16'($urandom());
      wr_ready = 1'b1;
      u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_WRITE, {4'h0, c}, b, m, d);
      u_sdp_ctrl_model.no_operation_state();
      for (int i = 0; i < 3 && wr_valid !== 1'b1; i++)
         u_sdp_ctrl_model.no_operation_state();
      seen = wr_valid;
      if (seen === 1'b1)
         `CHK("wr_entry", {b, rows[b], c, d, ~m}, wr_entry)
      u_sdp_ctrl_model.no_operation_state();
   endtask

   // Watchdog
   initial
   begin
      #(50 * 20000);
      err_total++;
      print_verdict();
   end

   // Main sequence
   initial
   begin
      void'($urandom(32'h2c689db3));
      nrst = 1'b0;
      rd_data = 16'h0000;
      wr_ready = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      `CHK("init_done", 1'b0, init_done)
      `CHK("mode_value", 12'h000, mode_value)
      end_test("reset");
      // Initialisation; accesses refused until the mode is set
      u_sdp_ctrl_model.power_up();
      repeat (8) u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_REFRESH, 12'h000, 2'h0, 2'h0,
         16'h0000);
      act(2'h0, 12'h0ff);
      rd(1'b0, 2'h0, 8'h12, 2'h0);
      `CHK("early read", 1'b0, seen)
      `CHK("init_done", 1'b0, init_done)
      u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_PRECHARGE, 12'h400, 2'h0, 2'h0, 16'h0000);
      mv = 12'($urandom());
      u_sdp_ctrl_model.mode_set(mv);
      `CHK("mode_value", mv, mode_value)
      `CHK("init_done", 1'b1, init_done)
      end_test("init");
      // Random reads and writes over all banks
      for (int b = 0; b < 4; b++)
         act(2'(b), 12'($urandom()));
      for (int i = 0; i < 6; i++)
      begin
         rd(1'b0, 2'($urandom()), 8'($urandom()), 2'($urandom()));
         `CHK("read seen", 1'b1, seen)
         wr(2'($urandom()), 8'($urandom()), 2'($urandom_range(2, 0)));
         `CHK("write seen", 1'b1, seen)
      end
      wr(2'h1, 8'hff, 2'h3);
      `CHK("masked write", 1'b0, seen)
      rd(1'b1, 2'h2, 8'h00, 2'h0);
      `CHK("deselected read", 1'b0, seen)
      end_test("access");
      // Single bank then all-bank precharge
      u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_PRECHARGE, 12'hbff, 2'h1, 2'h0, 16'h0000);
      rd(1'b0, 2'h1, 8'h01, 2'h0);
      `CHK("closed bank read", 1'b0, seen)
      rd(1'b0, 2'h2, 8'h02, 2'h1);
      `CHK("open bank read", 1'b1, seen)
      u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_PRECHARGE, 12'h400, 2'h2, 2'h0, 16'h0000);
      rd(1'b0, 2'h2, 8'h03, 2'h0);
      `CHK("all closed read", 1'b0, seen)
      end_test("precharge");
      // Clock enable low and back: power down, suspend, self refresh
      for (int k = 0; k < 3; k++)
      begin
         // Suspend needs an open bank
         if (k == 1)
            act(2'h0, 12'h3c3);
         // Self refresh needs all closed and a refresh beside low clock enable
         if (k == 2)
         begin
            u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_PRECHARGE, 12'h400, 2'h0, 2'h0,
               16'h0000);
            u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_REFRESH, 12'h000, 2'h0, 2'h0,
               16'h0000);
         end
         u_sdp_ctrl_model.set_cke(1'b0);
         u_sdp_ctrl_model.no_operation_state();
         `CHK("low_power", 1'b1, low_power)
         rd(1'b0, 2'h0, 8'h04, 2'h0);
         `CHK("low power read", 1'b0, seen)
         u_sdp_ctrl_model.set_cke(1'b1);
         u_sdp_ctrl_model.no_operation_state();
         `CHK("low_power", 1'b0, low_power)
      end
      end_test("clock_enable");
      // Fill the buffer with the core stalled, then drain it
      act(2'h3, 12'h0a5);
      wr_ready = 1'b0;
      repeat (20) u_sdp_ctrl_model.send(1'b0, sdp_pkg::CMD_WRITE, 12'h000, 2'h3, 2'h0,
         16'($urandom()));
      repeat (2) u_sdp_ctrl_model.no_operation_state();
      `CHK("wr_overflow", 1'b1, wr_overflow)
      wr_ready = 1'b1;
      n = 0;
      // Count the word already standing before each edge takes it
      repeat (40)
      begin
         n += (wr_valid === 1'b1);
         u_sdp_ctrl_model.no_operation_state();
      end
      `CHK("drained words", sdp_pkg::WR_FIFO_DEPTH + 1, n)
      end_test("buffer");
      print_verdict();
   end
endmodule
